// [rtl/psc_pkg.sv]
// shared constants and types of the pressure sensor command logic
package psc_pkg;
   localparam int CLK_MHZ = 100;
   localparam int TMR_W = 23;
   localparam logic [6:0] DEV_ADDR_A = 7'h25;
   localparam logic [6:0] DEV_ADDR_B = 7'h26;
   localparam logic [6:0] GC_ADDR = 7'h00;
   localparam logic [7:0] GC_RESET_BYTE = 8'h06;
   localparam logic [15:0] CMD_STOP = 16'h3ff9;
   localparam logic [15:0] CMD_TRIG_MF = 16'h3624;
   localparam logic [15:0] CMD_TRIG_MF_STR = 16'h3726;
   localparam logic [15:0] CMD_TRIG_DP = 16'h362f;
   localparam logic [15:0] CMD_TRIG_DP_STR = 16'h372d;
   localparam logic [15:0] CMD_SLEEP = 16'h3677;
   localparam logic [15:0] CMD_CONT_MF_AVG = 16'h3603;
   localparam logic [15:0] CMD_CONT_MF = 16'h3608;
   localparam logic [15:0] CMD_CONT_DP_AVG = 16'h3615;
   localparam logic [15:0] CMD_CONT_DP = 16'h361e;
   localparam logic [7:0] CRC_POLY = 8'h31;
   localparam logic [7:0] CRC_INIT = 8'hff;
   localparam logic [7:0] CRC_XOR = 8'h00;
   localparam logic [15:0] SCALE_FACTOR_PA = 16'h003c;
   localparam logic [3:0] RES_BYTES = 4'h9;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] IDLE_BYTE = 8'hff;
   localparam int STOP_DLY_US = 500;
   localparam int MEAS_MS = 45;
   localparam int RESET_MS = 2;
   localparam int WAKE_MS = 2;
   typedef enum logic [1:0] {
      RD_NACK = 2'h0,
      RD_ACK = 2'h1,
      RD_STRETCH = 2'h2
   } psc_rdmode_t;
   typedef enum logic [1:0] {
      EV_CMD = 2'h0,
      EV_GCRESET = 2'h1,
      EV_WAKE = 2'h2,
      EV_READ = 2'h3
   } psc_ev_t;
   typedef struct packed {
      psc_ev_t kind;
      logic [15:0] data;
   } psc_event_t;
   typedef struct packed {
      logic [15:0] pressure_word;
      logic [7:0] p_crc;
      logic [15:0] temp_word;
      logic [7:0] t_crc;
      logic [15:0] scale_word;
      logic [7:0] s_crc;
   } psc_result_t;
   typedef struct packed {
      psc_rdmode_t rd_mode;
      logic ack_write;
      logic asleep;
   } psc_ctrl_t;
   function automatic logic [7:0] crc8(input logic [15:0] w);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = 15; i >= 0; i--) begin
         c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
      end
      return c ^ CRC_XOR;
   endfunction : crc8
endpackage : psc_pkg

// [rtl/psc_link.sv]
// i2c slave byte engine running on the link clock
`timescale 1ns/1ps
`default_nettype none
module psc_link (
   input wire logic link_clk,
   input wire logic srst,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic addr_sel,
   input wire psc_pkg::psc_ctrl_t ctrl,
   input wire psc_pkg::psc_result_t result,
   output logic scl_oe,
   output logic sda_oe,
   output logic ev_tgl,
   output psc_pkg::psc_event_t ev
);
   import psc_pkg::*;
   typedef enum logic [7:0] {
      LS_IDLE = 8'h01,
      LS_ADDR = 8'h02,
      LS_AACK = 8'h04,
      LS_WR = 8'h08,
      LS_WACK = 8'h10,
      LS_STRETCH = 8'h20,
      LS_RD = 8'h40,
      LS_RACK = 8'h80
   } psc_lst_t;
   typedef struct packed {
      logic [1:0] rst_m;
      logic [1:0] scl_m;
      logic [1:0] sda_m;
      logic [1:0] sel_m;
      psc_ctrl_t ctrl_m0;
      psc_ctrl_t ctrl_m1;
      psc_result_t res_m0;
      psc_result_t res_m1;
      logic scl_p;
      logic sda_p;
      psc_lst_t st;
      logic [7:0] shreg;
      logic [3:0] bitcnt;
      logic [3:0] bytecnt;
      logic [7:0] cmd_hi;
      logic gc;
      logic sda_oe;
      logic scl_oe;
      logic ev_pend;
      logic ev_tgl;
      psc_event_t ev;
   } psc_link_st_t;
   psc_link_st_t q, d;
   logic scl, sda, rise, fall, start, stop, own;
   function automatic logic [7:0] byte_at(input psc_result_t r, input logic [3:0] idx);
      logic [71:0] s;
      s = r << {idx, 3'h0};
      return (idx < RES_BYTES) ? s[71:64] : IDLE_BYTE;
   endfunction : byte_at
   always_comb begin
      d = q;
      d.rst_m = {q.rst_m[0], srst};
      d.scl_m = {q.scl_m[0], scl_i};
      d.sda_m = {q.sda_m[0], sda_i};
      d.sel_m = {q.sel_m[0], addr_sel};
      d.ctrl_m0 = ctrl;
      d.ctrl_m1 = q.ctrl_m0;
      d.res_m0 = result;
      d.res_m1 = q.res_m0;
      scl = q.scl_m[1];
      sda = q.sda_m[1];
      d.scl_p = scl;
      d.sda_p = sda;
      rise = scl & ~q.scl_p;
      fall = ~scl & q.scl_p;
      start = scl & q.scl_p & q.sda_p & ~sda;
      stop = scl & q.scl_p & ~q.sda_p & sda;
      own = q.shreg[7:1] == (q.sel_m[1] ? DEV_ADDR_B : DEV_ADDR_A);
      d.ev_pend = 1'b0;
      if (q.ev_pend) begin
         d.ev_tgl = ~q.ev_tgl;
      end
      if (q.rst_m[1]) begin
         d.st = LS_IDLE;
         d.sda_oe = 1'b0;
         d.scl_oe = 1'b0;
         d.ev_tgl = 1'b0;
         d.ev = '0;
         d.bitcnt = '0;
         d.bytecnt = '0;
      end else if (stop) begin
         d.st = LS_IDLE;
         d.sda_oe = 1'b0;
         d.scl_oe = 1'b0;
      end else if (start) begin
         d.st = LS_ADDR;
         d.bitcnt = '0;
         d.bytecnt = '0;
         d.sda_oe = 1'b0;
         d.scl_oe = 1'b0;
      end else begin
         unique case (q.st)
            LS_IDLE: begin
            end
            LS_ADDR: begin
               if (rise) begin
                  d.shreg = {q.shreg[6:0], sda};
                  d.bitcnt = q.bitcnt + 4'h1;
               end else if (fall && q.bitcnt == BITS_PER_BYTE) begin
                  d.st = LS_IDLE;
                  d.gc = q.shreg[7:1] == GC_ADDR;
                  if (own && !q.shreg[0] && q.ctrl_m1.asleep) begin
                     d.ev = '{EV_WAKE, 16'h0000};
                     d.ev_pend = 1'b1;
                  end else if (!q.shreg[0] && q.ctrl_m1.ack_write && (own || d.gc)) begin
                     d.st = LS_AACK;
                     d.sda_oe = 1'b1;
                  end else if (own && q.shreg[0] && q.ctrl_m1.rd_mode != RD_NACK) begin
                     d.st = LS_AACK;
                     d.sda_oe = 1'b1;
                  end
               end
            end
            LS_AACK: begin
               if (fall) begin
                  d.bitcnt = '0;
                  d.sda_oe = 1'b0;
                  if (!q.shreg[0]) begin
                     d.st = LS_WR;
                  end else if (q.ctrl_m1.rd_mode == RD_STRETCH) begin
                     d.st = LS_STRETCH;
                     d.scl_oe = 1'b1;
                  end else begin
                     d.st = LS_RD;
                     d.shreg = byte_at(q.res_m1, 4'h0);
                     d.sda_oe = ~d.shreg[7];
                     d.ev = '{EV_READ, 16'h0000};
                     d.ev_pend = 1'b1;
                  end
               end
            end
            LS_WR: begin
               if (rise) begin
                  d.shreg = {q.shreg[6:0], sda};
                  d.bitcnt = q.bitcnt + 4'h1;
               end else if (fall && q.bitcnt == BITS_PER_BYTE) begin
                  d.st = LS_WACK;
                  d.sda_oe = 1'b1;
                  d.bytecnt = q.bytecnt + 4'h1;
                  if (q.gc) begin
                     if (q.shreg == GC_RESET_BYTE) begin
                        d.ev = '{EV_GCRESET, 16'h0000};
                        d.ev_pend = 1'b1;
                     end
                  end else if (q.bytecnt[0]) begin
                     d.ev = '{EV_CMD, {q.cmd_hi, q.shreg}};
                     d.ev_pend = 1'b1;
                  end else begin
                     d.cmd_hi = q.shreg;
                  end
               end
            end
            LS_WACK: begin
               if (fall) begin
                  d.sda_oe = 1'b0;
                  d.bitcnt = '0;
                  d.st = LS_WR;
               end
            end
            LS_STRETCH: begin
               if (q.ctrl_m1.rd_mode == RD_ACK) begin
                  d.scl_oe = 1'b0;
                  d.st = LS_RD;
                  d.shreg = byte_at(q.res_m1, 4'h0);
                  d.sda_oe = ~d.shreg[7];
                  d.ev = '{EV_READ, 16'h0000};
                  d.ev_pend = 1'b1;
               end
            end
            LS_RD: begin
               if (rise) begin
                  d.bitcnt = q.bitcnt + 4'h1;
               end else if (fall) begin
                  if (q.bitcnt == BITS_PER_BYTE) begin
                     d.sda_oe = 1'b0;
                     d.st = LS_RACK;
                  end else begin
                     d.shreg = {q.shreg[6:0], 1'b1};
                     d.sda_oe = ~q.shreg[6];
                  end
               end
            end
            LS_RACK: begin
               if (rise) begin
                  d.bytecnt = q.bytecnt + 4'h1;
                  d.st = sda ? LS_IDLE : LS_RACK;
               end else if (fall) begin
                  d.st = LS_RD;
                  d.bitcnt = '0;
                  d.shreg = byte_at(q.res_m1, q.bytecnt);
                  d.sda_oe = ~d.shreg[7];
               end
            end
         endcase
      end
   end
   always_ff @(posedge link_clk) begin
      q <= d;
   end
   assign scl_oe = q.scl_oe;
   assign sda_oe = q.sda_oe;
   assign ev_tgl = q.ev_tgl;
   assign ev = q.ev;
endmodule : psc_link
`default_nettype wire

// [rtl/psc_cmd_fsm.sv]
// command state machine of the pressure sensor with its i2c front end
`timescale 1ns/1ps
`default_nettype none
// Contract
// - stop code ends continuous, heater off, 500us
// - continuous accepts only stop and reset
// - decode mass flow triggers, plain and stretching
// - decode pressure triggers, plain and stretching
// - one trigger gives one measurement
// - busy 45ms after trigger, then readable
// - stretching trigger acks read, holds scl
// - plain trigger nacks reads until result
// - nine byte result with three checksums
// - master may end read early
// - scale word given per pascal
// - general call byte six resets device; the general call is acked only in idle and continuous
// - reset takes 2ms, no acks meanwhile
// - sleep only from idle, ignores reset
// - own write header wakes, not acked
// - awake within 2ms, master polls
// - answer one of two fixed addresses
// - commands 16 bit, words plus checksum
// - crc8 poly 31, init ff, no xor
// - data words are signed two's complement
module psc_cmd_fsm #(
   parameter int unsigned STOP_CYC = psc_pkg::STOP_DLY_US * psc_pkg::CLK_MHZ,
   parameter int unsigned MEAS_CYC = psc_pkg::MEAS_MS * 1000 * psc_pkg::CLK_MHZ,
   parameter int unsigned RESET_CYC = psc_pkg::RESET_MS * 1000 * psc_pkg::CLK_MHZ,
   parameter int unsigned WAKE_CYC = psc_pkg::WAKE_MS * 1000 * psc_pkg::CLK_MHZ
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic link_clk,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic addr_sel,
   input wire logic [15:0] meas_pressure,
   input wire logic [15:0] meas_temp,
   input wire logic meas_valid,
   output logic heater_on,
   output logic meas_start,
   output logic comp_mass_flow,
   output logic cont_run,
   output logic asleep
);
   import psc_pkg::*;
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_CONT = 7'h02,
      ST_STOPPING = 7'h04,
      ST_MEAS = 7'h08,
      ST_RESETTING = 7'h10,
      ST_SLEEP = 7'h20,
      ST_WAKING = 7'h40
   } psc_st_t;
   typedef struct packed {
      psc_st_t st;
      logic [TMR_W-1:0] tmr;
      logic res_ready;
      logic stretch;
      logic mass_flow;
      logic heater;
      logic start_p;
      psc_result_t result;
      psc_ctrl_t ctrl;
      logic [2:0] tgl_m;
      psc_event_t ev_m0;
      psc_event_t ev_m1;
   } psc_core_st_t;
   localparam logic [TMR_W-1:0] STOP_LD = TMR_W'(STOP_CYC - 1);
   localparam logic [TMR_W-1:0] MEAS_LD = TMR_W'(MEAS_CYC - 1);
   localparam logic [TMR_W-1:0] RESET_LD = TMR_W'(RESET_CYC - 1);
   localparam logic [TMR_W-1:0] WAKE_LD = TMR_W'(WAKE_CYC - 1);
   psc_core_st_t q, d;
   logic link_tgl;
   psc_event_t link_ev;
   logic ev_hit;
   logic tmr_done;
   logic is_trig;
   logic is_cont;
   function automatic psc_result_t make_result(input logic [15:0] p,
                                               input logic [15:0] t);
      psc_result_t r;
      r.pressure_word = p;
      r.p_crc = crc8(p);
      r.temp_word = t;
      r.t_crc = crc8(t);
      r.scale_word = SCALE_FACTOR_PA;
      r.s_crc = crc8(SCALE_FACTOR_PA);
      return r;
   endfunction : make_result
   function automatic logic trig_code(input logic [15:0] c);
      return c == CMD_TRIG_MF
         || c == CMD_TRIG_MF_STR
         || c == CMD_TRIG_DP
         || c == CMD_TRIG_DP_STR;
   endfunction : trig_code
   function automatic logic cont_code(input logic [15:0] c);
      return c == CMD_CONT_MF_AVG
         || c == CMD_CONT_MF
         || c == CMD_CONT_DP_AVG
         || c == CMD_CONT_DP;
   endfunction : cont_code
   function automatic logic mf_code(input logic [15:0] c);
      return c == CMD_TRIG_MF
         || c == CMD_TRIG_MF_STR
         || c == CMD_CONT_MF_AVG
         || c == CMD_CONT_MF;
   endfunction : mf_code
   function automatic logic str_code(input logic [15:0] c);
      return c == CMD_TRIG_MF_STR
         || c == CMD_TRIG_DP_STR;
   endfunction : str_code
   psc_link u_link (
      .link_clk(link_clk),
      .srst(srst),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .addr_sel(addr_sel),
      .ctrl(q.ctrl),
      .result(q.result),
      .scl_oe(scl_oe),
      .sda_oe(sda_oe),
      .ev_tgl(link_tgl),
      .ev(link_ev)
   );
   always_comb begin
      d = q;
      d.tgl_m = {q.tgl_m[1:0], link_tgl};
      d.ev_m0 = link_ev;
      d.ev_m1 = q.ev_m0;
      ev_hit = q.tgl_m[1] ^ q.tgl_m[2];
      tmr_done = q.tmr == '0;
      d.tmr = tmr_done ? q.tmr : q.tmr - TMR_W'(1);
      d.start_p = 1'b0;
      is_trig = trig_code(q.ev_m1.data);
      is_cont = cont_code(q.ev_m1.data);
      unique case (q.st)
         ST_MEAS: begin
            if (tmr_done) begin
               d.st = ST_IDLE;
               d.heater = 1'b0;
               d.res_ready = 1'b1;
               d.result = make_result(meas_pressure, meas_temp);
            end
         end
         ST_CONT: begin
            if (meas_valid) begin
               d.res_ready = 1'b1;
               d.result = make_result(meas_pressure, meas_temp);
            end
         end
         ST_STOPPING, ST_RESETTING, ST_WAKING: begin
            if (tmr_done) begin
               d.st = ST_IDLE;
            end
         end
         ST_IDLE, ST_SLEEP: begin
         end
      endcase
      if (ev_hit) begin
         unique case (q.ev_m1.kind)
            EV_GCRESET: begin
               if (q.st != ST_SLEEP && q.st != ST_RESETTING) begin
                  d.st = ST_RESETTING;
                  d.tmr = RESET_LD;
                  d.res_ready = 1'b0;
                  d.stretch = 1'b0;
                  d.mass_flow = 1'b0;
                  d.heater = 1'b0;
                  d.start_p = 1'b0;
                  d.result = '0;
               end
            end
            EV_WAKE: begin
               if (q.st == ST_SLEEP) begin
                  d.st = ST_WAKING;
                  d.tmr = WAKE_LD;
               end
            end
            EV_READ: begin
               if (q.st == ST_IDLE) begin
                  d.res_ready = 1'b0;
               end
            end
            EV_CMD: begin
               if (q.st == ST_CONT) begin
                  if (q.ev_m1.data == CMD_STOP) begin
                     d.st = ST_STOPPING;
                     d.tmr = STOP_LD;
                     d.heater = 1'b0;
                     d.res_ready = 1'b0;
                  end
               end else if (q.st == ST_IDLE) begin
                  if (is_trig) begin
                     d.st = ST_MEAS;
                     d.tmr = MEAS_LD;
                     d.stretch = str_code(q.ev_m1.data);
                     d.mass_flow = mf_code(q.ev_m1.data);
                     d.heater = 1'b1;
                     d.start_p = 1'b1;
                     d.res_ready = 1'b0;
                  end else if (is_cont) begin
                     d.st = ST_CONT;
                     d.mass_flow = mf_code(q.ev_m1.data);
                     d.heater = 1'b1;
                     d.start_p = 1'b1;
                     d.res_ready = 1'b0;
                  end else if (q.ev_m1.data == CMD_SLEEP) begin
                     d.st = ST_SLEEP;
                  end else if (q.ev_m1.data == CMD_STOP) begin
                     d.st = ST_STOPPING;
                     d.tmr = STOP_LD;
                  end
               end
            end
         endcase
      end
      d.ctrl.ack_write = d.st == ST_IDLE || d.st == ST_CONT;
      d.ctrl.asleep = d.st == ST_SLEEP;
      if (d.res_ready) begin
         d.ctrl.rd_mode = RD_ACK;
      end else if (d.st == ST_MEAS && d.stretch) begin
         d.ctrl.rd_mode = RD_STRETCH;
      end else begin
         d.ctrl.rd_mode = RD_NACK;
      end
      if (srst) begin
         d.st = ST_IDLE;
         d.tmr = '0;
         d.res_ready = 1'b0;
         d.stretch = 1'b0;
         d.mass_flow = 1'b0;
         d.heater = 1'b0;
         d.start_p = 1'b0;
         d.result = '0;
         d.ctrl = '{RD_NACK, 1'b1, 1'b0};
         d.tgl_m = '0;
         d.ev_m0 = '0;
         d.ev_m1 = '0;
      end
   end
   always_ff @(posedge core_clk) begin
      q <= d;
   end
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign heater_on = q.heater;
   assign meas_start = q.start_p;
   assign comp_mass_flow = q.mass_flow;
   assign cont_run = q.st == ST_CONT;
   assign asleep = q.st == ST_SLEEP;
endmodule : psc_cmd_fsm
`default_nettype wire

// [verification/psc_cmd_fsm_props.sv]
// assertion checker for the pressure sensor command logic
`timescale 1ns/1ps
`default_nettype none
module psc_cmd_fsm_props #(
   parameter int unsigned MEAS_CYC = 200
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic link_clk,
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic addr_sel,
   input wire logic [15:0] meas_pressure,
   input wire logic [15:0] meas_temp,
   input wire logic meas_valid,
   input wire logic heater_on,
   input wire logic meas_start,
   input wire logic comp_mass_flow,
   input wire logic cont_run,
   input wire logic asleep
);
   typedef struct packed {
      logic [31:0] hcnt;
      logic [9:0] scnt;
   } psc_chk_t;
   psc_chk_t st_q;
   psc_chk_t st_d;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);
   // heater run length and sleep length
   always_comb begin
      st_d = st_q;
      st_d.hcnt = (heater_on && !cont_run) ? st_q.hcnt + 32'h1 : 32'h0;
      st_d.scnt = !asleep ? 10'h0 : ((st_q.scnt == 10'h3ff) ? st_q.scnt : st_q.scnt + 10'h1);
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   start_pulse_a: assert property (meas_start |=> !meas_start)
      else $error("start pulse too long");
   start_heat_a: assert property (meas_start ##2 !cont_run |-> heater_on)
      else $error("heater not on after trigger");
   heat_bound_a: assert property (st_q.hcnt <= MEAS_CYC + 8)
      else $error("measurement runs too long");
   sleep_idle_a: assert property (asleep |-> !heater_on && !cont_run && !meas_start)
      else $error("activity while asleep");
   sleep_quiet_a: assert property (st_q.scnt > 10'hc8 |-> !sda_oe && !scl_oe)
      else $error("bus driven while asleep");
   stop_heat_a: assert property ($fell(cont_run) |-> ##[0:3] !heater_on)
      else $error("heater stays on after stop");
   cont_start_a: assert property (cont_run && $past(cont_run) |-> !meas_start)
      else $error("trigger taken in continuous");
   comp_hold_a: assert property (heater_on && $past(heater_on) |-> $stable(comp_mass_flow))
      else $error("compensation changed mid run");
   stretch_busy_a: assert property ($rose(scl_oe) |-> heater_on)
      else $error("stretch outside measurement");
endmodule : psc_cmd_fsm_props
bind psc_cmd_fsm psc_cmd_fsm_props #(.MEAS_CYC(MEAS_CYC)) i_psc_cmd_fsm_props (
   .core_clk(core_clk), .srst(srst), .link_clk(link_clk), .scl_i(scl_i), .scl_o(scl_o),
   .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel(addr_sel),
   .meas_pressure(meas_pressure), .meas_temp(meas_temp), .meas_valid(meas_valid),
   .heater_on(heater_on), .meas_start(meas_start), .comp_mass_flow(comp_mass_flow),
   .cont_run(cont_run), .asleep(asleep)
);
`default_nettype wire

// [verification/psc_master.sv]
// i2c bus master model driving the sensor link
`timescale 1ns/1ps
`default_nettype none
module psc_master #(
   parameter int H = 16
) (
   input wire logic clk,
   input wire logic scl,
   input wire logic sda,
   output logic scl_low,
   output logic sda_low,
   output logic to_err
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      to_err = 1'b0;
   end
   task automatic hw();
      repeat (H) @(negedge clk);
   endtask : hw
   // one bit, waiting while the clock is stretched
   task automatic bitx(input logic v, output logic r);
      int n;
      hw();
      sda_low = !v;
      hw();
      scl_low = 1'b0;
      n = 0;
      while (scl !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 20000) to_err = 1'b1;
      hw();
      r = sda;
      scl_low = 1'b1;
   endtask : bitx
   task automatic start();
      sda_low = 1'b1;
      hw();
      scl_low = 1'b1;
   endtask : start
   task automatic stop();
      hw();
      sda_low = 1'b1;
      hw();
      scl_low = 1'b0;
      hw();
      sda_low = 1'b0;
      hw();
   endtask : stop
   task automatic wr(input logic [7:0] d, output logic ak);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ak = !r;
   endtask : wr
   task automatic rd(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(last, r);
   endtask : rd
endmodule : psc_master
`default_nettype wire

// [verification/psc_cmd_fsm_tb.sv]
// self-checking bench of the pressure sensor command logic
`timescale 1ns/1ps
`default_nettype none
module psc_cmd_fsm_tb;
   import psc_pkg::*;
   localparam int MC = 2000;
   localparam int SC = 1000;
   localparam int RC = 1000;
   localparam logic [7:0] WA = 8'h4a;
   localparam logic [7:0] RA = 8'h4b;
   logic core_clk = 1'b0;
   logic link_clk = 1'b0;
   logic srst = 1'b1;
   logic addr_sel = 1'b0;
   logic meas_valid = 1'b0;
   logic [15:0] mp = 16'h0;
   logic [15:0] mt = 16'h0;
   logic scl_oe, sda_oe, scl_o, sda_o, m_scl, m_sda, to_err, ack;
   logic heater_on, meas_start, comp_mass_flow, cont_run, asleep;
   logic [7:0] b;
   logic [7:0] exp_q[$];
   logic [31:0] rnd = 32'h28052a27;
   logic [15:0] trig[4] = '{CMD_TRIG_MF, CMD_TRIG_MF_STR, CMD_TRIG_DP, CMD_TRIG_DP_STR};
   int err_count = 0;
   int n_tests = 0;
   int starts = 0;
   wire logic scl = !(m_scl || scl_oe);
   wire logic sda = !(m_sda || sda_oe);
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #3;
      forever #16 link_clk = ~link_clk;
   end
   always @(posedge core_clk) begin
      if (meas_start === 1'b1) starts++;
   end
   psc_cmd_fsm #(.STOP_CYC(SC), .MEAS_CYC(MC), .RESET_CYC(RC), .WAKE_CYC(RC)) i_psc_cmd_fsm (
      .core_clk(core_clk), .srst(srst), .link_clk(link_clk), .scl_i(scl), .scl_o(scl_o),
      .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel(addr_sel),
      .meas_pressure(mp), .meas_temp(mt), .meas_valid(meas_valid), .heater_on(heater_on),
      .meas_start(meas_start), .comp_mass_flow(comp_mass_flow), .cont_run(cont_run),
      .asleep(asleep)
   );
   psc_master #(.H(16)) i_psc_master (.clk(core_clk), .scl(scl), .sda(sda),
      .scl_low(m_scl), .sda_low(m_sda), .to_err(to_err));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [7:0] crc(input logic [15:0] w);
      logic [7:0] c;
      c = 8'hff;
      for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
      return c;
   endfunction : crc
   task automatic chk_ack(input logic got, input logic e);
      n_tests++;
      if (got !== e) begin
         err_count++;
         $display("[ERR] %0t ack got %b exp %b", $time, got, e);
      end
   endtask : chk_ack
   task automatic chk_val(input logic [15:0] got, input logic [15:0] e);
      n_tests++;
      if (got !== e) begin
         err_count++;
         $display("[ERR] %0t value got %h exp %h", $time, got, e);
      end
   endtask : chk_val
   task automatic send(input logic [7:0] a, input logic [15:0] w, input int nb, output logic ak);
      logic d;
      i_psc_master.start();
      i_psc_master.wr(a, ak);
      for (int k = 0; k < nb && ak; k++) i_psc_master.wr(k ? w[7:0] : w[15:8], d);
      i_psc_master.stop();
      repeat (40) @(negedge core_clk);
   endtask : send
   task automatic rd_res(input int n, output logic ak);
      i_psc_master.start();
      i_psc_master.wr(RA, ak);
      for (int k = 0; k < n && ak; k++) begin
         i_psc_master.rd(k == n - 1, b);
         chk_val({8'h0, b}, {8'h0, exp_q[k]});
      end
      i_psc_master.stop();
   endtask : rd_res
   task automatic close_out();
      if (to_err !== 1'b0) err_count++;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (100000) @(posedge core_clk);
      err_count++;
      close_out();
   end
   initial begin
      repeat (10) @(negedge core_clk);
      srst = 1'b0;
      addr_sel = 1'b1;
      repeat (30) @(negedge core_clk);
      send(8'h4c, 16'h0, 0, ack);
      chk_ack(ack, 1'b1);
      send(WA, 16'h0, 0, ack);
      chk_ack(ack, 1'b0);
      addr_sel = 1'b0;
      repeat (30) @(negedge core_clk);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         mp = rnd[15:0];
         mt = rnd[31:16];
         exp_q = {mp[15:8], mp[7:0], crc(mp), mt[15:8], mt[7:0], crc(mt), SCALE_FACTOR_PA[15:8],
                  SCALE_FACTOR_PA[7:0], crc(SCALE_FACTOR_PA)};
         send(WA, trig[i], 2, ack);
         chk_ack(ack, 1'b1);
         chk_val({15'h0, comp_mass_flow}, {15'h0, i < 2});
         if (trig[i][8]) begin
            rd_res(i == 1 ? 3 : 9, ack);
            chk_ack(ack, 1'b1);
         end else begin
            send(WA, 16'h0, 0, ack);
            chk_ack(ack, 1'b0);
            rd_res(9, ack);
            chk_ack(ack, 1'b0);
            for (int t = 0; t < 200 && !ack; t++) rd_res(9, ack);
            chk_ack(ack, 1'b1);
         end
         rd_res(1, ack);
         chk_ack(ack, 1'b0);
      end
      chk_val(16'(starts), 16'h4);
      send(WA, 16'h1234, 2, ack);
      rd_res(1, ack);
      chk_ack(ack, 1'b0);
      chk_val({15'h0, heater_on}, 16'h0);
      send(WA, CMD_CONT_DP, 2, ack);
      meas_valid = 1'b1;
      @(negedge core_clk);
      meas_valid = 1'b0;
      rd_res(3, ack);
      chk_ack(ack, 1'b1);
      send(WA, CMD_TRIG_MF, 2, ack);
      chk_val({14'h0, cont_run, comp_mass_flow}, 16'h2);
      send(WA, CMD_STOP, 2, ack);
      chk_val({14'h0, cont_run, heater_on}, 16'h0);
      send(WA, 16'h0, 0, ack);
      chk_ack(ack, 1'b0);
      repeat (SC) @(negedge core_clk);
      send(WA, 16'h0, 0, ack);
      chk_ack(ack, 1'b1);
      send(WA, CMD_CONT_MF, 2, ack);
      send(8'h00, {GC_RESET_BYTE, 8'h0}, 1, ack);
      chk_val({15'h0, cont_run}, 16'h0);
      send(WA, 16'h0, 0, ack);
      chk_ack(ack, 1'b0);
      repeat (RC) @(negedge core_clk);
      send(WA, CMD_SLEEP, 2, ack);
      chk_ack(ack, 1'b1);
      chk_val({15'h0, asleep}, 16'h1);
      send(8'h00, {GC_RESET_BYTE, 8'h0}, 1, ack);
      chk_ack(ack, 1'b0);
      send(WA, 16'h0, 0, ack);
      chk_ack(ack, 1'b0);
      for (int t = 0; t < 20 && !ack; t++) send(WA, 16'h0, 0, ack);
      chk_ack(ack, 1'b1);
      chk_val({15'h0, asleep}, 16'h0);
      chk_val({14'h0, scl_o, sda_o}, 16'h0);
      close_out();
   end
endmodule : psc_cmd_fsm_tb
`default_nettype wire
